// file: rtl/tmi_pkg.sv
// Shared constants for the temperature monitor two-wire slave and its master
package tmi_pkg;
  // Bus addresses
  localparam logic [6:0] DEV_ADDR     = 7'h4C;
  localparam logic [6:0] ARA_ADDR     = 7'h0C;
  // Register pointer values, read side
  localparam logic [7:0] PTR_LOC_T    = 8'h00;
  localparam logic [7:0] PTR_REM_T    = 8'h01;
  localparam logic [7:0] PTR_STAT     = 8'h02;
  localparam logic [7:0] PTR_CFG_RD   = 8'h03;
  localparam logic [7:0] PTR_LHI_RD   = 8'h05;
  localparam logic [7:0] PTR_LLO_RD   = 8'h06;
  localparam logic [7:0] PTR_RHI_RD   = 8'h07;
  localparam logic [7:0] PTR_RLO_RD   = 8'h08;
  // Register pointer values, write side
  localparam logic [7:0] PTR_CFG_WR   = 8'h09;
  localparam logic [7:0] PTR_LHI_WR   = 8'h0B;
  localparam logic [7:0] PTR_LLO_WR   = 8'h0C;
  localparam logic [7:0] PTR_RHI_WR   = 8'h0D;
  localparam logic [7:0] PTR_RLO_WR   = 8'h0E;
  localparam logic [7:0] PTR_ONE_SHOT = 8'h0F;
  // Reset values
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [7:0] LHI_RST      = 8'h55;
  localparam logic [7:0] LLO_RST      = 8'h00;
  localparam logic [7:0] RHI_RST      = 8'h55;
  localparam logic [7:0] RLO_RST      = 8'h00;
  localparam logic [7:0] VAL_RST      = 8'h00;
  localparam logic [7:0] PTR_RST      = 8'h00;
  // Field positions
  localparam int CFG_STANDBY = 6;
  localparam int CFG_PIN_CMP = 5;
  localparam int ST_BUSY     = 7;
  localparam int ST_LHIGH    = 6;
  localparam int ST_LLOW     = 5;
  localparam int ST_RHIGH    = 4;
  localparam int ST_RLOW     = 3;
  localparam int ST_OPEN     = 2;
  // Bit counting within a byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Master bus clock timing
  localparam longint SYS_FREQ_HZ = 200_000_000;
  localparam longint SCL_FREQ_HZ = 1_000_000;
  localparam int     QTR_CYC     = int'(SYS_FREQ_HZ / (4 * SCL_FREQ_HZ));
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
endpackage

// file: rtl/tmi_bus_if.sv
// Two-wire bus and alert line joining master and temperature monitor slave
`timescale 1ns/1ps
interface tmi_bus_if;
  // Master drives
  logic host_scl_o;
  logic host_scl_oe_b;
  logic host_sda_o;
  logic host_sda_oe_b;
  // Slave drives
  logic dev_sda_o;
  logic dev_sda_oe_b;
  logic dev_alert_o;
  logic dev_alert_oe_b;
  // Other bus members, driven by the bench only
  logic ext_sda_oe_b;
  logic ext_alert_oe_b;
  // Wired-AND levels with pull-ups
  logic scl;
  logic sda;
  logic alert_b;
  assign scl     = host_scl_oe_b | host_scl_o;
  assign sda     = (host_sda_oe_b | host_sda_o) & (dev_sda_oe_b | dev_sda_o) & ext_sda_oe_b;
  assign alert_b = (dev_alert_oe_b | dev_alert_o) & ext_alert_oe_b;
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_b,
               output dev_alert_o, output dev_alert_oe_b);
  modport host (input sda, input alert_b, output host_scl_o, output host_scl_oe_b,
                output host_sda_o, output host_sda_oe_b);
endinterface

// file: rtl/tmi_dev.sv
// Temperature monitor two-wire slave with register file and alert output
//
// Contract
// - Answer only fixed address 0x4C
// - Start then seven address bits, direction bit
// - Acknowledge own address on ninth clock
// - Direction zero writes, one reads
// - Nine clocks per byte, receiver acknowledges
// - Data changes only while clock low
// - Master ends read with no-acknowledge, stop
// - First written byte loads register pointer
// - Second written byte stores to selected register
// - Read returns register at retained pointer
// - Separate read and write pointer values
// - Alert on out-of-limit or open sensor
// - Answer alert response address with own address
// - Lose arbitration, withdraw from the bus
// - Release alert after answer if fault gone
// - Master repeats alert response while line low
// - Configuration bit six enters standby, abort conversion
// - One-shot pointer write converts once in standby
// - Limits writable in standby, still compared
// - Sample open comparator at conversion start
// - Status flags stick until status read
// - Pointer undefined at power-on, load first
`timescale 1ns/1ps
module tmi_dev
  import tmi_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Two-wire bus and alert pin
  tmi_bus_if.dev          bus,
  // Converter side
  input  wire logic       remote_open,
  input  wire logic       conv_done,
  input  wire logic [7:0] loc_val,
  input  wire logic [7:0] rem_val,
  output logic            conv_start,
  output logic            conv_abort,
  output logic            standby
);

  typedef enum logic [6:0] {
    D_IDLE = 7'h01,
    D_ADDR = 7'h02,
    D_AACK = 7'h04,
    D_RX   = 7'h08,
    D_WACK = 7'h10,
    D_TX   = 7'h20,
    D_TACK = 7'h40
  } tmi_dst_t;

  typedef struct packed {
    tmi_dst_t   st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic       ara;
    logic       first;
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic [7:0] lval;
    logic [7:0] rval;
    logic [7:0] stat;
    logic       busy;
    logic       os_pend;
    logic       os_run;
    logic       sda_o;
    logic       sda_oe_b;
    logic       alert_o;
    logic       alert_oe_b;
    logic       conv_start;
    logic       conv_abort;
    logic       standby;
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic [1:0] open_sy;
  } tmi_dev_state_t;

  tmi_dev_state_t r;
  tmi_dev_state_t n;

  // High and low trips of one channel, signed compare
  function automatic logic [1:0] tmi_trip(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    tmi_trip = {$signed(v) > $signed(hi), $signed(v) < $signed(lo)};
  endfunction

  logic       scl_s;
  logic       sda_s;
  logic       scl_p;
  logic       sda_p;
  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic [1:0] ltrip;
  logic [1:0] rtrip;
  logic       cond;
  logic [7:0] rd_byte;
  logic [7:0] tx_byte;
  logic [7:0] set_f;
  logic       stat_clr;

  // Bus conditions from the second and third sync stages only
  assign scl_s   = r.scl_sy[1];
  assign sda_s   = r.sda_sy[1];
  assign scl_p   = r.scl_sy[2];
  assign sda_p   = r.sda_sy[2];
  assign rise    = scl_s & ~scl_p;
  assign fall    = ~scl_s & scl_p;
  assign start_c = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c  = scl_s & scl_p & ~sda_p & sda_s;

  // Live limit checks run even in standby, so new limits take effect at once
  assign ltrip = tmi_trip(r.lval, r.lhi, r.llo);
  assign rtrip = tmi_trip(r.rval, r.rhi, r.rlo);
  assign cond  = (|ltrip) | (|rtrip) | r.stat[ST_OPEN];

  // Read decode; write-only pointers read as zero
  always_comb begin
    case (r.ptr)
      PTR_LOC_T:  rd_byte = r.lval;
      PTR_REM_T:  rd_byte = r.rval;
      PTR_STAT:   rd_byte = {r.busy, r.stat[6:0]};
      PTR_CFG_RD: rd_byte = r.cfg;
      PTR_LHI_RD: rd_byte = r.lhi;
      PTR_LLO_RD: rd_byte = r.llo;
      PTR_RHI_RD: rd_byte = r.rhi;
      PTR_RLO_RD: rd_byte = r.rlo;
      default:    rd_byte = VAL_RST;
    endcase
  end

  assign tx_byte = r.ara ? {DEV_ADDR, 1'b1} : rd_byte;

  // Next state
  always_comb begin
    n            = r;
    n.conv_start = 1'b0;
    n.conv_abort = 1'b0;
    stat_clr     = 1'b0;
    set_f        = 8'h00;
    n.scl_sy     = {r.scl_sy[1:0], bus.scl};
    n.sda_sy     = {r.sda_sy[1:0], bus.sda};
    n.open_sy    = {r.open_sy[0], remote_open};

    case (r.st)
      D_IDLE: begin
      end
      D_ADDR: begin
        if (rise) begin
          n.sh  = {r.sh[6:0], sda_s};
          n.cnt = r.cnt + 4'h1;
        end else if (fall && r.cnt == BYTE_BITS) begin
          n.rw  = r.sh[0];
          n.ara = 1'b0;
          if (r.sh[7:1] == DEV_ADDR) begin
            n.sda_oe_b = 1'b0;
            n.st       = D_AACK;
          end else if (r.sh[7:1] == ARA_ADDR && r.sh[0] && !r.alert_oe_b) begin
            n.ara      = 1'b1;
            n.sda_oe_b = 1'b0;
            n.st       = D_AACK;
          end else begin
            n.st = D_IDLE;
          end
        end
      end
      D_AACK: begin
        if (fall) begin
          n.cnt      = 4'h0;
          n.first    = 1'b1;
          n.sda_oe_b = 1'b1;
          if (r.rw) begin
            n.sh       = tx_byte;
            n.sda_oe_b = tx_byte[7];
            stat_clr   = !r.ara && r.ptr == PTR_STAT;
            n.st       = D_TX;
          end else begin
            n.st = D_RX;
          end
        end
      end
      D_RX: begin
        if (rise) begin
          n.sh  = {r.sh[6:0], sda_s};
          n.cnt = r.cnt + 4'h1;
        end else if (fall && r.cnt == BYTE_BITS) begin
          n.sda_oe_b = 1'b0;
          n.first    = 1'b0;
          n.st       = D_WACK;
          if (r.first) begin
            n.ptr = r.sh;
          end else begin
            case (r.ptr)
              PTR_CFG_WR:   n.cfg = r.sh;
              PTR_LHI_WR:   n.lhi = r.sh;
              PTR_LLO_WR:   n.llo = r.sh;
              PTR_RHI_WR:   n.rhi = r.sh;
              PTR_RLO_WR:   n.rlo = r.sh;
              PTR_ONE_SHOT: n.os_pend = r.cfg[CFG_STANDBY];
              default:      n.ptr = r.ptr;
            endcase
          end
        end
      end
      D_WACK: begin
        if (fall) begin
          n.sda_oe_b = 1'b1;
          n.cnt      = 4'h0;
          n.st       = D_RX;
        end
      end
      D_TX: begin
        if (rise) begin
          if (r.sda_oe_b && !sda_s) begin
            n.st = D_IDLE;
          end else begin
            n.cnt = r.cnt + 4'h1;
          end
        end else if (fall) begin
          if (r.cnt == BYTE_BITS) begin
            n.sda_oe_b = 1'b1;
            n.st       = D_TACK;
          end else begin
            n.sh       = {r.sh[6:0], 1'b0};
            n.sda_oe_b = r.sh[6];
          end
        end
      end
      D_TACK: begin
        if (rise) begin
          if (r.ara && !cond) begin
            n.alert_oe_b = 1'b1;
          end
          if (sda_s) begin
            n.st = D_IDLE;
          end
        end else if (fall) begin
          n.cnt      = 4'h0;
          n.sh       = tx_byte;
          n.sda_oe_b = tx_byte[7];
          stat_clr   = !r.ara && r.ptr == PTR_STAT;
          n.st       = D_TX;
        end
      end
      default: begin
        n.st       = D_IDLE;
        n.sda_oe_b = 1'b1;
      end
    endcase

    // A start or stop overrides any byte in flight
    if (stop_c) begin
      n.st       = D_IDLE;
      n.sda_oe_b = 1'b1;
    end
    if (start_c) begin
      n.st       = D_ADDR;
      n.cnt      = 4'h0;
      n.sda_oe_b = 1'b1;
    end

    // Converter control: free running, halted in standby, single shot on demand
    if (!r.busy && (!r.cfg[CFG_STANDBY] || r.os_pend)) begin
      n.busy       = 1'b1;
      n.conv_start = 1'b1;
      n.os_run     = r.cfg[CFG_STANDBY];
      n.os_pend    = 1'b0;
      set_f[ST_OPEN] = r.open_sy[1];
    end else if (r.busy && r.cfg[CFG_STANDBY] && !r.os_run) begin
      n.busy       = 1'b0;
      n.conv_abort = 1'b1;
    end else if (r.busy && conv_done) begin
      n.busy   = 1'b0;
      n.os_run = 1'b0;
      n.lval   = loc_val;
      n.rval   = rem_val;
    end
    n.standby = n.cfg[CFG_STANDBY];

    // Sticky flags; a new trip in the clearing cycle survives the read
    set_f[ST_LHIGH] = ltrip[1];
    set_f[ST_LLOW]  = ltrip[0];
    set_f[ST_RHIGH] = rtrip[1];
    set_f[ST_RLOW]  = rtrip[0];
    n.stat = (stat_clr ? 8'h00 : r.stat) | set_f;

    // Alert only in alert pin mode; comparator mode leaves the line released
    if (r.cfg[CFG_PIN_CMP]) begin
      n.alert_oe_b = 1'b1;
    end else if (cond) begin
      n.alert_oe_b = 1'b0;
    end
  end

  // State register; pointer gets a fixed value though software must load it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r            <= '0;
      r.st         <= D_IDLE;
      r.ptr        <= PTR_RST;
      r.cfg        <= CFG_RST;
      r.lhi        <= LHI_RST;
      r.llo        <= LLO_RST;
      r.rhi        <= RHI_RST;
      r.rlo        <= RLO_RST;
      r.lval       <= VAL_RST;
      r.rval       <= VAL_RST;
      r.sda_oe_b   <= 1'b1;
      r.alert_oe_b <= 1'b1;
      r.scl_sy     <= 3'h7;
      r.sda_sy     <= 3'h7;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign bus.dev_sda_o      = r.sda_o;
  assign bus.dev_sda_oe_b   = r.sda_oe_b;
  assign bus.dev_alert_o    = r.alert_o;
  assign bus.dev_alert_oe_b = r.alert_oe_b;
  assign conv_start         = r.conv_start;
  assign conv_abort         = r.conv_abort;
  assign standby            = r.standby;

endmodule

// file: rtl/tmi_host.sv
// Two-wire bus master issuing single pointer, write and read transactions
`timescale 1ns/1ps
module tmi_host
  import tmi_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Two-wire bus and alert line
  tmi_bus_if.host         bus,
  // Request side
  input  wire logic       req,
  input  wire logic       req_rd,
  input  wire logic [6:0] req_addr,
  input  wire logic [1:0] req_wlen,
  input  wire logic [7:0] req_wdata0,
  input  wire logic [7:0] req_wdata1,
  // Answer side
  output logic            busy,
  output logic            done,
  output logic            nack,
  output logic [7:0]      rdata,
  output logic            alert_low
);

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } tmi_hst_t;

  typedef struct packed {
    tmi_hst_t   st;
    logic [7:0] tick;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [1:0] last;
    logic [7:0] sh;
    logic [7:0] w1;
    logic       rd;
    logic       busy;
    logic       done;
    logic       nack;
    logic [7:0] rdata;
    logic       alert_low;
    logic       scl_o;
    logic       scl_oe_b;
    logic       sda_o;
    logic       sda_oe_b;
    logic [1:0] sda_sy;
    logic [1:0] al_sy;
  } tmi_host_state_t;

  tmi_host_state_t r;
  tmi_host_state_t n;
  logic            qt;
  logic            sending;

  // One quarter of the bus clock period elapses on each qt
  assign qt      = r.tick == QTR_LAST;
  assign sending = (r.byten == 2'h0) | ~r.rd;

  always_comb begin
    n           = r;
    n.done      = 1'b0;
    n.sda_sy    = {r.sda_sy[0], bus.sda};
    n.al_sy     = {r.al_sy[0], bus.alert_b};
    n.alert_low = ~r.al_sy[1];
    n.tick      = (qt || r.st == H_IDLE) ? 8'h00 : r.tick + 8'h01;
    case (r.st)
      H_IDLE: begin
        if (req) begin
          n.sh    = {req_addr, req_rd};
          n.w1    = req_wdata1;
          n.rd    = req_rd;
          n.last  = req_rd ? 2'h1 : req_wlen;
          n.rdata = req_wdata0;
          n.byten = 2'h0;
          n.bitn  = 4'h0;
          n.q     = 2'h0;
          n.nack  = 1'b0;
          n.busy  = 1'b1;
          n.st    = H_START;
        end
      end
      H_START: begin
        if (qt) begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.scl_oe_b = 1'b1;
            2'h1: n.sda_oe_b = 1'b0;
            2'h2: n.scl_oe_b = 1'b0;
            default: n.st = H_BIT;
          endcase
        end
      end
      H_BIT: begin
        if (qt) begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: begin
              if (r.bitn < BYTE_BITS) begin
                n.sda_oe_b = sending ? r.sh[7] : 1'b1;
              end else begin
                n.sda_oe_b = sending | (r.byten == r.last);
              end
            end
            2'h1: n.scl_oe_b = 1'b1;
            2'h2: begin
              if (r.bitn < BYTE_BITS) begin
                n.sh = {r.sh[6:0], r.sda_sy[1]};
              end else if (sending && r.sda_sy[1]) begin
                n.nack = 1'b1;
              end
            end
            default: begin
              n.scl_oe_b = 1'b0;
              n.bitn     = r.bitn + 4'h1;
              if (r.bitn == BYTE_BITS) begin
                n.bitn = 4'h0;
                if (!sending) begin
                  n.rdata = r.sh;
                end
                if (r.nack || r.byten == r.last) begin
                  n.st = H_STOP;
                end else begin
                  n.byten = r.byten + 2'h1;
                  n.sh    = (r.byten == 2'h0) ? r.rdata : r.w1;
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (qt) begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.sda_oe_b = 1'b0;
            2'h1: n.scl_oe_b = 1'b1;
            2'h2: n.sda_oe_b = 1'b1;
            default: begin
              n.st   = H_IDLE;
              n.busy = 1'b0;
              n.done = 1'b1;
            end
          endcase
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  // State register; both lines released at reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r          <= '0;
      r.st       <= H_IDLE;
      r.scl_oe_b <= 1'b1;
      r.sda_oe_b <= 1'b1;
      r.sda_sy   <= 2'h3;
      r.al_sy    <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign bus.host_scl_o    = r.scl_o;
  assign bus.host_scl_oe_b = r.scl_oe_b;
  assign bus.host_sda_o    = r.sda_o;
  assign bus.host_sda_oe_b = r.sda_oe_b;
  assign busy              = r.busy;
  assign done              = r.done;
  assign nack              = r.nack;
  assign rdata             = r.rdata;
  assign alert_low         = r.alert_low;

endmodule

// file: testbench/tmi_sva.sv
// Checker for the two-wire link between master and temperature monitor slave
`timescale 1ns/1ps
module tmi_sva
  import tmi_pkg::*;
(
  // Clock and reset
  input logic sys_clk,
  input logic rst_b,
  // Wire levels
  input logic scl,
  input logic sda,
  // Slave drives
  input logic dev_sda_o,
  input logic dev_sda_oe_b,
  input logic dev_alert_o,
  input logic dev_alert_oe_b
);
  logic       scl_q;
  logic       sda_q;
  logic       acked;
  logic       mism;
  logic       beaten;
  logic [4:0] rise_cnt;
  logic [7:0] a_sh;
  logic [7:0] d_sh;
  wire        rise  = scl & ~scl_q;
  wire        start = scl & scl_q & sda_q & ~sda;
  wire        own_a = a_sh[7:1] == DEV_ADDR;
  wire        ara_a = a_sh[7:1] == ARA_ADDR;

  // Bit tracker; counts rises since start, saturating so long reads never wrap
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      acked    <= 1'b0;
      mism     <= 1'b0;
      beaten   <= 1'b0;
      rise_cnt <= 5'h0;
      a_sh     <= 8'h00;
      d_sh     <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        rise_cnt <= 5'h0;
        mism     <= 1'b0;
        beaten   <= 1'b0;
      end else if (rise) begin
        if (rise_cnt != 5'h1F) rise_cnt <= rise_cnt + 5'h1;
        if (rise_cnt < 5'h8) a_sh <= {a_sh[6:0], sda};
        if (rise_cnt > 5'h8 && rise_cnt < 5'h11) d_sh <= {d_sh[6:0], sda};
        if (rise_cnt == 5'h8) acked <= ~sda;
        if (rise_cnt == 5'h8 && !own_a && !(ara_a && !dev_alert_oe_b)) mism <= 1'b1;
        // Slave left a read data bit released but the line was low: another member won
        if (rise_cnt > 5'h8 && rise_cnt < 5'h11 && a_sh[0] && acked && dev_sda_oe_b && !sda) beaten <= 1'b1;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Ninth and eighteenth clock rises after a start
  sequence s_ack_slot;
    rise && rise_cnt == 5'h8;
  endsequence
  sequence s_mack_slot;
    rise && rise_cnt == 5'h11;
  endsequence

  sda_stable_a: assert property (scl && scl_q |-> $stable(dev_sda_oe_b))
    else $error("slave data moved while clock high");
  addr_quiet_a: assert property (rise_cnt < 5'h8 |-> dev_sda_oe_b)
    else $error("slave drove data during address byte");
  own_ack_a: assert property (s_ack_slot ##0 own_a |-> !dev_sda_oe_b)
    else $error("own address not acknowledged");
  ack_hold_a: assert property (s_ack_slot ##0 !dev_sda_oe_b |-> !dev_sda_oe_b [*8])
    else $error("acknowledge dropped early");
  mism_quiet_a: assert property (mism |-> dev_sda_oe_b)
    else $error("slave active after foreign address");
  ara_ack_a: assert property (s_ack_slot ##0 (a_sh == {ARA_ADDR, 1'b1} && !dev_alert_oe_b) |-> !dev_sda_oe_b)
    else $error("alert response address not acknowledged");
  ara_data_a: assert property (s_mack_slot ##0 (ara_a && a_sh[0] && acked && !beaten) |-> d_sh == {DEV_ADDR, 1'b1})
    else $error("wrong address returned to alert response");
  read_nack_a: assert property (s_mack_slot ##0 (a_sh[0] && acked) |-> sda)
    else $error("master acknowledged last read byte");
  alert_free_a: assert property ($rose(dev_alert_oe_b) |-> ara_a && rise_cnt == 5'h12)
    else $error("alert released outside alert response");
  drain_only_a: assert property (dev_sda_o == 1'b0 && dev_alert_o == 1'b0)
    else $error("slave drove a line high");
  lost_quiet_a: assert property (beaten |-> dev_sda_oe_b)
    else $error("slave kept driving after losing arbitration");
endmodule

// file: testbench/temp_monitor_i2c_slave_alert_tb.sv
// Self-checking bench joining the two-wire master and the temperature monitor slave
`timescale 1ns/1ps
module temp_monitor_i2c_slave_alert_tb
  import tmi_pkg::*;
;
  logic       sys_clk;
  logic       rst_b;
  logic       req;
  logic       req_rd;
  logic [6:0] req_addr;
  logic [1:0] req_wlen;
  logic [7:0] req_wdata0;
  logic [7:0] req_wdata1;
  logic [7:0] rdata;
  logic       busy;
  logic       done;
  logic       nack;
  logic       alert_low;
  logic       remote_open;
  logic       conv_done;
  logic [7:0] loc_val;
  logic [7:0] rem_val;
  logic       conv_start;
  logic       conv_abort;
  logic       standby;
  logic [4:0] conv_cnt;
  int         failures;
  int         cmp_count;
  int         starts;
  int         s0;

  tmi_bus_if bus_if ();
  tmi_dev tmi_dev_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus_if), .remote_open(remote_open),
    .conv_done(conv_done), .loc_val(loc_val), .rem_val(rem_val), .conv_start(conv_start),
    .conv_abort(conv_abort), .standby(standby));
  tmi_host tmi_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus_if), .req(req), .req_rd(req_rd),
    .req_addr(req_addr), .req_wlen(req_wlen), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
    .busy(busy), .done(done), .nack(nack), .rdata(rdata), .alert_low(alert_low));
  tmi_sva tmi_sva_inst (.sys_clk(sys_clk), .rst_b(rst_b), .scl(bus_if.scl), .sda(bus_if.sda),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe_b(bus_if.dev_sda_oe_b), .dev_alert_o(bus_if.dev_alert_o),
    .dev_alert_oe_b(bus_if.dev_alert_oe_b));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Converter stand-in; an abort drops the pending result as the slave expects
  always @(negedge sys_clk) begin
    if (!rst_b) begin
      conv_done <= 1'b0;
      conv_cnt  <= 5'h00;
      starts    <= 0;
    end else begin
      conv_done <= (conv_cnt == 5'h01);
      if (conv_start === 1'b1) begin
        conv_cnt <= 5'h14;
        starts   <= starts + 1;
      end else if (conv_abort === 1'b1 || conv_cnt == 5'h00) begin
        conv_cnt <= 5'h00;
      end else begin
        conv_cnt <= conv_cnt - 5'h01;
      end
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One whole transaction; req is held a single cycle since the master takes it only when idle
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [1:0] n, input logic [7:0] w0,
                      input logic [7:0] w1);
    int k;
    @(negedge sys_clk);
    req        = 1'b1;
    req_rd     = rd;
    req_addr   = a;
    req_wlen   = n;
    req_wdata0 = w0;
    req_wdata1 = w1;
    @(negedge sys_clk);
    req = 1'b0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge sys_clk);
    check("done", {7'h0, done}, 8'h01);
    check("busy", {7'h0, busy}, 8'h00);
    check("nack", {7'h0, nack}, {7'h0, a != DEV_ADDR && a != ARA_ADDR});
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence; limits are written in standby so trips come from stored values
  initial begin
    sys_clk     = 1'b0;
    rst_b       = 1'b0;
    req         = 1'b0;
    req_rd      = 1'b0;
    req_addr    = 7'h00;
    req_wlen    = 2'h0;
    req_wdata0  = 8'h00;
    req_wdata1  = 8'h00;
    remote_open = 1'b0;
    loc_val     = 8'h20;
    rem_val     = 8'h10;
    failures    = 0;
    cmp_count   = 0;
    bus_if.ext_sda_oe_b   = 1'b1;
    bus_if.ext_alert_oe_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (200) @(negedge sys_clk);
    check("alert idle", {7'h0, alert_low}, 8'h00);
    xfer(1'b0, DEV_ADDR, 2'h2, PTR_CFG_WR, 8'h40);
    check("standby", {7'h0, standby}, 8'h01);
    xfer(1'b0, DEV_ADDR + 7'h01, 2'h0, 8'h00, 8'h00);
    xfer(1'b0, DEV_ADDR, 2'h2, PTR_LHI_WR, 8'h10);
    repeat (20) @(negedge sys_clk);
    check("alert trip", {7'h0, alert_low}, 8'h01);
    remote_open = 1'b1;
    s0 = starts;
    xfer(1'b0, DEV_ADDR, 2'h2, PTR_ONE_SHOT, 8'hA5);
    xfer(1'b0, DEV_ADDR, 2'h1, PTR_STAT, 8'h00);
    xfer(1'b1, DEV_ADDR, 2'h0, 8'h00, 8'h00);
    check("status", rdata, (8'h01 << ST_LHIGH) | (8'h01 << ST_OPEN));
    check("one-shot count", 8'(starts - s0), 8'h01);
    xfer(1'b0, DEV_ADDR, 2'h2, PTR_LHI_WR, LHI_RST);
    repeat (20) @(negedge sys_clk);
    check("alert held", {7'h0, alert_low}, 8'h01);
    xfer(1'b1, ARA_ADDR, 2'h0, 8'h00, 8'h00);
    check("alert answer", rdata, {DEV_ADDR, 1'b1});
    repeat (20) @(negedge sys_clk);
    check("alert released", {7'h0, alert_low}, 8'h00);
    xfer(1'b0, DEV_ADDR, 2'h2, PTR_LHI_WR, 8'h10);
    xfer(1'b0, DEV_ADDR, 2'h2, PTR_LHI_WR, LHI_RST);
    // A second member alerts too and wins the data byte by pulling all eight bits low
    bus_if.ext_alert_oe_b = 1'b0;
    fork
      xfer(1'b1, ARA_ADDR, 2'h0, 8'h00, 8'h00);
      begin
        repeat (10) @(negedge bus_if.scl);
        @(negedge sys_clk);
        bus_if.ext_sda_oe_b = 1'b0;
        repeat (8) @(negedge bus_if.scl);
        @(negedge sys_clk);
        bus_if.ext_sda_oe_b = 1'b1;
      end
    join
    check("ara winner", rdata, 8'h00);
    check("loser alert", {7'h0, bus_if.dev_alert_oe_b}, 8'h00);
    bus_if.ext_alert_oe_b = 1'b1;
    // Keep asking while the shared line stays low
    for (s0 = 0; s0 < 4 && alert_low === 1'b1; s0++) xfer(1'b1, ARA_ADDR, 2'h0, 8'h00, 8'h00);
    check("ara retries", 8'(s0), 8'h01);
    check("ara second", rdata, {DEV_ADDR, 1'b1});
    give_verdict();
  end

  // Watchdog; twelve transactions at 200 cycles a bit need about 58k cycles
  initial begin
    repeat (80000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end
endmodule
